//--- verilog/capture_pkg.sv
// Package: register map, field layout, modes and reset values of the capture channel
package capture_pkg;
  localparam logic [7:0]  ctrl_offset        = 8'h00;
  localparam logic [7:0]  fifo_offset        = 8'h04;
  localparam logic [7:0]  status_offset      = 8'h08;
  localparam logic [7:0]  int_status_offset  = 8'h0c;
  localparam logic [7:0]  int_mask_offset    = 8'h10;
  localparam logic [7:0]  timer_offset       = 8'h14;
  // capture_control field positions
  localparam int          mode_lsb           = 0;
  localparam int          first_rise_bit     = 3;
  localparam int          int_count_lsb      = 5;
  localparam int          timer32_bit        = 7;
  localparam int          timer_sel_bit      = 8;
  localparam int          enable_bit         = 15;
  localparam logic [31:0] ctrl_reset         = 32'h0000_0000;
  localparam logic [31:0] ctrl_write_mask    = 32'h0000_81ef;
  // Interrupt status bit positions
  localparam int          irq_thresh_bit     = 0;
  localparam int          irq_event_bit      = 1;
  localparam int          irq_ovf_bit        = 2;
  localparam logic [2:0]  irq_reset          = 3'h0;
  localparam int          fifo_depth         = 4;
  localparam logic [1:0]  div4_last          = 2'h3;
  localparam logic [3:0]  div16_last         = 4'hf;
  typedef enum logic [2:0] {
    mode_off, mode_every_edge, mode_fall, mode_rise,
    mode_div4, mode_div16, mode_first_edge, mode_int_only
  } mode_type;
endpackage : capture_pkg

//--- verilog/capture_edge_detect.sv
// Pin synchroniser and edge detector for the capture input
module capture_edge_detect (
  input  wire logic pclk,        // Bus clock
  input  wire logic presetn,     // Async reset, active low
  input  wire logic pin,         // Asynchronous pin level
  output logic      level,       // Synchronised level
  output logic      rise,        // One-cycle rising edge pulse
  output logic      fall         // One-cycle falling edge pulse
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;
endmodule : capture_edge_detect

//--- verilog/capture_fifo.sv
// Four-entry capture FIFO with occupancy count
module capture_fifo (
  input  wire logic        pclk,     // Bus clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        push,     // Store wdata
  input  wire logic [31:0] wdata,    // Captured value
  input  wire logic        pop,      // Drop oldest entry
  input  wire logic        flush,    // Empty the buffer
  output logic      [31:0] rdata,    // Oldest entry
  output logic      [2:0]  count     // Entries held
);
  import capture_pkg::*;
  logic [31:0] mem_q [fifo_depth];
  logic [1:0]  wr_q;
  logic [1:0]  rd_q;
  logic [2:0]  count_q;
  logic        do_push;
  logic        do_pop;

  assign do_push = push && (count_q != 3'(fifo_depth));
  assign do_pop  = pop && (count_q != 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < fifo_depth; i++) mem_q[i] <= 32'h0000_0000;
    end else if (do_push) begin
      mem_q[wr_q] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q    <= 2'h0;
      rd_q    <= 2'h0;
      count_q <= 3'h0;
    end else if (flush) begin
      wr_q    <= 2'h0;
      rd_q    <= 2'h0;
      count_q <= 3'h0;
    end else begin
      if (do_push) wr_q <= wr_q + 2'h1;
      if (do_pop) rd_q <= rd_q + 2'h1;
      count_q <= count_q + 3'(do_push) - 3'(do_pop);
    end
  end

  assign rdata = mem_q[rd_q];
  assign count = count_q;
endmodule : capture_fifo

//--- verilog/input_capture_channel.sv
// Input capture channel: pin edge modes, time base select, FIFO, interrupts, APB
//
// Chosen here: the APB interface to the registers and the address map.
module input_capture_channel (
  input  wire logic        pclk,              // Peripheral bus clock, 10 MHz
  input  wire logic        presetn,           // Async reset, active low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB access phase
  input  wire logic        pwrite,            // APB write
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error, unmapped address
  input  wire logic        capture_input_pin, // External capture pin
  input  wire logic [15:0] first_time_base,   // Timer A count
  input  wire logic [15:0] second_time_base,  // Timer B count
  input  wire logic        cpu_sleep,         // CPU in Sleep or Idle
  output logic             irq,               // Level interrupt
  output logic             wake               // Wake request pulse
);
  import capture_pkg::*;

  logic [31:0] ctrl_q;
  logic [2:0]  int_stat_q;
  logic [2:0]  int_mask_q;
  logic        overflow_q;
  logic        armed_q;
  logic [3:0]  pre_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        wake_q;
  logic        level;
  logic        rise;
  logic        fall;
  logic [31:0] fifo_data;
  logic [2:0]  fifo_count;
  logic        wr_en;
  logic        rd_en;
  logic        setup;
  logic        capture;
  logic        pin_event;
  logic        fifo_pop;
  logic        flush;
  logic [31:0] time_value;
  logic [2:0]  set_bits;
  logic        thresh_hit;
  mode_type    mode;
  logic        enabled;
  logic        bus_take;
  logic [2:0]  clear_bits;
  logic [31:0] ctrl_d;
  logic [2:0]  int_mask_d;
  logic [31:0] status_word;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : addr_hit

  // Every mapped word answers; anything else is refused
  function automatic logic addr_mapped(input logic [7:0] a);
    return addr_hit(a, ctrl_offset) || addr_hit(a, fifo_offset)
        || addr_hit(a, status_offset) || addr_hit(a, int_status_offset)
        || addr_hit(a, int_mask_offset) || addr_hit(a, timer_offset);
  endfunction : addr_mapped

  capture_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (capture_input_pin),
    .level   (level),
    .rise    (rise),
    .fall    (fall)
  );

  assign enabled = ctrl_q[enable_bit];
  assign mode    = mode_type'(ctrl_q[mode_lsb +: 3]);
  // Time base mux; cascaded form puts the second timer in the upper half
  always_comb begin
    time_value = {16'h0000, first_time_base};
    if (ctrl_q[timer32_bit]) begin
      time_value = {second_time_base, first_time_base};
    end else if (ctrl_q[timer_sel_bit]) begin
      time_value = {16'h0000, second_time_base};
    end
  end

  // Qualifying event per mode
  always_comb begin
    capture   = 1'b0;
    pin_event = 1'b0;
    if (enabled) begin
      case (mode)
        mode_off:        capture = 1'b0;
        mode_every_edge: capture = rise | fall;
        mode_fall:       capture = fall;
        mode_rise:       capture = rise;
        mode_div4:       capture = rise && pre_q[1:0] == div4_last;
        mode_div16:      capture = rise && pre_q == div16_last;
        mode_first_edge: begin
          if (armed_q) capture = rise | fall;
          else capture = ctrl_q[first_rise_bit] ? rise : fall;
        end
        mode_int_only:   pin_event = cpu_sleep && (rise | fall);
        default:         capture = 1'b0;
      endcase
    end
  end

  // Prescaler restarts whenever the channel is disabled or in neither counting mode; a switch between div4 and div16 keeps its count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 4'h0;
    end else if (!enabled || (mode != mode_div4 && mode != mode_div16)) begin
      pre_q <= 4'h0;
    end else if (rise) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // Arming restarts whenever the channel leaves the first-edge mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (!enabled || mode != mode_first_edge) begin
      armed_q <= 1'b0;
    end else if (capture) begin
      armed_q <= 1'b1;
    end
  end

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_q;
  assign rd_en = psel && penable && !pwrite && pready_q;
  assign fifo_pop = rd_en && addr_hit(paddr, fifo_offset);
  // Disabling the channel drops stale captures
  assign flush = !enabled;

  capture_fifo u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (capture),
    .wdata   (time_value),
    .pop     (fifo_pop),
    .flush   (flush),
    .rdata   (fifo_data),
    .count   (fifo_count)
  );

  // Count threshold field holds entries minus one
  assign thresh_hit = capture
                   && (fifo_count == {1'b0, ctrl_q[int_count_lsb +: 2]});

  always_comb begin
    set_bits = 3'h0;
    set_bits[irq_thresh_bit] = thresh_hit && fifo_count != 3'(fifo_depth);
    set_bits[irq_event_bit]  = capture | pin_event;
    set_bits[irq_ovf_bit]    = capture && fifo_count == 3'(fifo_depth);
  end

  // Only implemented control bits take write data; the rest read as zero
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_en && addr_hit(paddr, ctrl_offset)) begin
      ctrl_d = pwdata & ctrl_write_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ctrl_reset;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_comb begin
    int_mask_d = int_mask_q;
    if (wr_en && addr_hit(paddr, int_mask_offset)) begin
      int_mask_d = pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_q <= irq_reset;
    end else begin
      int_mask_q <= int_mask_d;
    end
  end

  // Software clears by writing ones
  always_comb begin
    clear_bits = 3'h0;
    if (wr_en && addr_hit(paddr, int_status_offset)) begin
      clear_bits = pwdata[2:0];
    end
  end

  // Set wins over write-one-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= irq_reset;
    end else begin
      int_stat_q <= (int_stat_q & ~clear_bits) | set_bits;
    end
  end

  // Overflow holds until the buffer is read, or the channel is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_q <= 1'b0;
    end else if (set_bits[irq_ovf_bit]) begin
      overflow_q <= 1'b1;
    end else if (fifo_pop || flush) begin
      overflow_q <= 1'b0;
    end
  end

  // New sets feed the level directly, so the interrupt lags its event by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((int_stat_q | set_bits) & int_mask_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= cpu_sleep && (capture || pin_event);
    end
  end

  // One wait state: ready in the second access cycle
  assign bus_take = setup || (psel && penable && !pready_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else if (bus_take) begin
      pready_q <= psel && penable;
    end else begin
      pready_q <= 1'b0;
    end
  end

  // Error rises in the first access cycle, one cycle ahead of ready, and drops with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (bus_take) begin
      pslverr_q <= !addr_mapped(paddr);
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Live pin level sits above the arming flag for software polling
  assign status_word = {26'h0, level, armed_q, overflow_q, fifo_count};

  // Read word is taken before the pop that the same access causes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (bus_take) begin
      case (paddr)
        ctrl_offset:       prdata_q <= ctrl_q;
        fifo_offset:       prdata_q <= fifo_data;
        status_offset:     prdata_q <= status_word;
        int_status_offset: prdata_q <= {29'h0, int_stat_q};
        int_mask_offset:   prdata_q <= {29'h0, int_mask_q};
        timer_offset:      prdata_q <= time_value;
        default:           prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  assign wake    = wake_q;
endmodule : input_capture_channel

//--- verification/capture_pin_model.sv
// Behavioural source of the external signal on the capture pin
module capture_pin_model (
  input  wire logic pclk, // Bus clock, paces the edges
  output logic      pin   // Capture pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 1'b0;
  // Hold sets the pace; below 1 cycle the synchroniser may miss a level
  task automatic flip(input int hold);
    pin <= ~pin;
    repeat (hold) @(posedge pclk);
  endtask : flip
endmodule : capture_pin_model

//--- verification/input_capture_channel_props.sv
// Checker: bus handshake, error, interrupt and wake relations of the capture channel
module input_capture_channel_props import capture_pkg::*; (
  input wire logic        pclk,      // Bus clock
  input wire logic        presetn,   // Async reset, active low
  input wire logic        psel,      // APB select
  input wire logic        penable,   // APB access phase
  input wire logic        pwrite,    // APB write
  input wire logic [7:0]  paddr,     // APB address
  input wire logic [31:0] prdata,    // APB read data
  input wire logic        pready,    // APB ready
  input wire logic        pslverr,   // APB error
  input wire logic        cpu_sleep, // CPU in Sleep or Idle
  input wire logic        irq,       // Level interrupt
  input wire logic        wake       // Wake pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("access did not end after exactly one wait state");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_err_unmapped: assert property (psel && !penable && paddr > timer_offset |=> ##1 pslverr)
    else $error("unmapped address not refused");
  a_err_mapped: assert property (psel && !penable && paddr <= timer_offset && paddr[1:0] == 2'h0
    |=> ##1 !pslverr)
    else $error("mapped address refused");
  a_err_no_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_irq_sticky: assert property (irq && !psel && !$past(psel) |=> irq)
    else $error("interrupt dropped without software access");
  a_wake_sleep: assert property (wake |-> cpu_sleep || $past(cpu_sleep))
    else $error("wake outside Sleep or Idle");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
endmodule : input_capture_channel_props

bind input_capture_channel input_capture_channel_props u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .cpu_sleep,
  .irq, .wake
);

//--- verification/input_capture_channel_tb.sv
// Self-checking bench for the input capture channel
module input_capture_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import capture_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        cpu_sleep = 1'b0, pready, pslverr, pin, irq, wake, perr;
  logic [7:0]  paddr = 8'h00;
  logic [15:0] tmr_a = 16'h0000, tmr_b = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  int          mismatches = 0, comparisons = 0, wakes = 0;

  input_capture_channel DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .capture_input_pin(pin), .first_time_base(tmr_a), .second_time_base(tmr_b), .cpu_sleep,
    .irq, .wake
  );
  capture_pin_model pm (.pclk, .pin);

  always #50 pclk = ~pclk;
  always @(posedge pclk) if (wake === 1'b1) wakes++;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Request held until ready is sampled high, then released
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    // Idle cycle before each access keeps clear of a just-disabled channel
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No fixed wait is assumed; only the watchdog ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Time bases move before each edge, so every capture is traceable to its edge
  task automatic edges(input int n);
    for (int i = 0; i < n; i++) begin
      tmr_a <= 16'h1000 + 16'(i);
      tmr_b <= 16'h2000 + 16'(i);
      pm.flip(8);
    end
  endtask : edges

  task automatic t_reset();
    logic [7:0] regs[4] = '{ctrl_offset, status_offset, int_status_offset, int_mask_offset};
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset value", rdata, 32'h0);
    end
    apb(1'b1, 8'h18, 32'hffff_ffff);
    chk("unmapped write error", 32'(perr), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped read data", rdata, 32'h0);
    apb(1'b1, ctrl_offset, 32'hffff_ffff);
    apb(1'b0, ctrl_offset, 32'h0);
    chk("control writable bits", rdata, ctrl_write_mask);
    apb(1'b1, ctrl_offset, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_modes();
    logic [31:0] cfg[9] = '{32'h8000, 32'h8001, 32'h8002, 32'h8003, 32'h8004, 32'h8005,
                            32'h8005, 32'h8006, 32'h800e};
    int          nf[9] = '{4, 4, 4, 4, 16, 30, 32, 4, 4};
    int          nc[9] = '{0, 4, 2, 2, 2, 0, 1, 3, 4};
    foreach (cfg[i]) begin
      apb(1'b1, ctrl_offset, 32'h0);
      apb(1'b1, ctrl_offset, cfg[i]);
      edges(nf[i]);
      apb(1'b0, status_offset, 32'h0);
      chk("captures per mode", rdata & 32'hf, 32'(nc[i]));
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_fifo();
    apb(1'b1, ctrl_offset, 32'h0);
    apb(1'b1, int_status_offset, 32'h7);
    apb(1'b1, ctrl_offset, 32'h8081);
    edges(5);
    apb(1'b0, status_offset, 32'h0);
    chk("full with overflow", rdata & 32'hf, 32'hc);
    chk("pin level seen", rdata & 32'h20, 32'h20);
    apb(1'b0, int_status_offset, 32'h0);
    chk("overflow event", rdata & 32'h4, 32'h4);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, fifo_offset, 32'h0);
      chk("cascaded capture", rdata, {16'h2000 + 16'(i), 16'h1000 + 16'(i)});
    end
    apb(1'b0, status_offset, 32'h0);
    chk("drained", rdata & 32'hf, 32'h0);
    apb(1'b1, ctrl_offset, 32'h0);
    pm.flip(8);
    apb(1'b1, ctrl_offset, 32'h8103);
    edges(2);
    apb(1'b0, fifo_offset, 32'h0);
    chk("second timer capture", rdata, 32'h0000_2000);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_irq();
    apb(1'b1, ctrl_offset, 32'h0);
    apb(1'b1, int_status_offset, 32'h7);
    apb(1'b1, int_mask_offset, 32'h1);
    apb(1'b1, ctrl_offset, 32'h8043);
    edges(4);
    chk("irq below threshold", 32'(irq), 32'h0);
    edges(2);
    chk("irq at threshold", 32'(irq), 32'h1);
    apb(1'b0, int_status_offset, 32'h0);
    chk("threshold and event", rdata & 32'h7, 32'h3);
    apb(1'b1, int_mask_offset, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1'b1, int_mask_offset, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq on event", 32'(irq), 32'h1);
    apb(1'b1, ctrl_offset, 32'h0);
    apb(1'b1, int_status_offset, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'(irq), 32'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic t_sleep();
    int w0;
    w0 = wakes;
    apb(1'b1, int_mask_offset, 32'h7);
    apb(1'b1, ctrl_offset, 32'h8007);
    edges(2);
    apb(1'b0, int_status_offset, 32'h0);
    chk("interrupt only while awake", rdata, 32'h0);
    chk("no wake while awake", 32'(wakes - w0), 32'h0);
    cpu_sleep <= 1'b1;
    edges(2);
    chk("irq in sleep", 32'(irq), 32'h1);
    chk("wake in sleep", 32'(wakes != w0), 32'h1);
    apb(1'b0, int_status_offset, 32'h0);
    chk("event in sleep", rdata & 32'h2, 32'h2);
    cpu_sleep <= 1'b0;
    apb(1'b1, ctrl_offset, 32'h0);
    $display("test sleep done");
  endtask : t_sleep

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // Whole run needs about 1250 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_fifo();
    t_irq();
    t_sleep();
    conclude();
  end
endmodule : input_capture_channel_tb
